// ===== core/wsw_pkg.sv
// Purpose: Shared constants, layouts and types for the watchdog and sleep block
// Assumes: One 25 MHz clock; register index times four gives the APB byte address
// Notes:   Interrupt bit layout is fixed here and used by the wake mask
package wsw_pkg;
  localparam int              CLK_HZ         = 25_000_000;
  localparam int              APB_AW         = 12;
  localparam int              BYTE_SHIFT     = 2;
  localparam logic [7:0]      IDX_OPTION     = 8'h81;
  localparam logic [7:0]      IDX_STATUS     = 8'h03;
  localparam int              STAT_PD_BIT    = 3;
  localparam int              STAT_TO_BIT    = 4;
  localparam logic [7:0]      OPT_RESET      = 8'hFF;
  localparam int              PS_W           = 3;
  localparam int              PRESC_W        = 7;
  // Base period in microseconds and one watchdog RC tick in microseconds
  localparam int              WDT_PERIOD_US  = 18000;
  localparam int              RC_TICK_US     = 1;
  localparam int              WDT_BASE_TICKS = WDT_PERIOD_US / RC_TICK_US;
  localparam int              PC_W           = 13;
  localparam logic [PC_W-1:0] IRQ_VECTOR     = 13'h0004;
  localparam logic [PC_W-1:0] PC_STEP        = 13'h0001;
  // 0 ext pin, 1 port change, 2 timer0, 3 timer_one async, 4 serial start/stop,
  // 5 serial slave, 6 capture, 7 parallel slave, 8 rc conversion, 9 usart slave, 10 other
  localparam int              NUM_IRQ        = 11;
  localparam logic [10:0]     WAKE_CAPABLE   = 11'h03FB;

  typedef struct packed {
    logic [3:0] misc;
    logic       prescaler_assign;
    logic [2:0] prescale_ratio_select;
  } wsw_opt_s;

  typedef struct packed {
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } wsw_flag_s;

  typedef enum {
    WSW_RUN,
    WSW_SLEEP
  } wsw_state_e;
endpackage

// ===== core/wsw_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk_i
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/10ps
module wsw_sync3 #(
  parameter int              W        = 1,
  parameter logic [W-1:0]    RST_VAL  = '0
) (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic [W-1:0]  async_i,
  output logic      [W-1:0]  sync_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          sync_o[g] <= RST_VAL[g];
        end else if (s2_reg[g] == s3_reg[g]) begin
          sync_o[g] <= s3_reg[g];
        end
      end
    end
  endgenerate
endmodule // wsw_sync3

// ===== core/wsw_top.sv
// Purpose: Watchdog timer with prescaler and sleep/wake control, APB registers
// Assumes: Core gives one-cycle instruction strobes; irq flags and enables on clk_i
// Notes:   Watchdog ticks come from the RC oscillator pin, not from clk_i
//
// How it works
// - Interrupt take pushes only return PC
// - Watchdog counts own RC oscillator ticks
// - Awake time-out gives watchdog device reset
// - Asleep time-out wakes and resumes execution
// - Cleared enable fuse disables watchdog permanently
// - Base period is fixed tick count
// - Option register prescaler up to 1:128
// - Clear and sleep reset count, prescaler
// - Asleep watchdog never resets, only wakes
// - Any time-out clears time-out flag
// - Sleep clears watchdog and power-down flag, sets time-out flag, stops oscillator
// - Pins hold their drive during sleep
// - Wake on master clear, watchdog, interrupt
// - Master clear resets, others resume execution
// - Power-down flag set at power-up and by the clear instruction
// - Only clockless peripherals can wake device
// - Sleep prefetches instruction at PC plus one
// - Wake needs individual enable, ignores global
// - Wake vectors to 0004h when global set
// - Pending interrupt turns sleep into no-op
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module wsw_top #(
  parameter int BASE_TICKS = wsw_pkg::WDT_BASE_TICKS
) (
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [wsw_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic                       wdt_rc_clk_i,
  input  wire logic                       master_clear_pin_n_i,
  input  wire logic                       watchdog_enable_fuse_i,
  input  wire logic                       watchdog_clear_instr_i,
  input  wire logic                       sleep_instr_i,
  input  wire logic                       global_irq_enable_i,
  input  wire logic [wsw_pkg::PC_W-1:0]   pc_i,
  input  wire logic [wsw_pkg::NUM_IRQ-1:0] irq_flag_i,
  input  wire logic [wsw_pkg::NUM_IRQ-1:0] irq_enable_i,
  output logic                            dev_reset_o,
  output logic                            wdt_reset_o,
  output logic                            osc_drive_en_o,
  output logic                            io_hold_o,
  output logic                            wake_o,
  output logic                            wake_vector_o,
  output logic      [wsw_pkg::PC_W-1:0]   resume_pc_o,
  output logic                            stack_push_o,
  output logic      [wsw_pkg::PC_W-1:0]   stack_data_o,
  output logic                            vector_load_o,
  output logic      [wsw_pkg::PC_W-1:0]   vector_addr_o,
  output logic                            timeout_flag_n_o,
  output logic                            powerdown_flag_n_o
);
  import wsw_pkg::*;

  localparam logic [31:0] BASE_MAX = 32'(BASE_TICKS - 1);

  wsw_state_e             state_reg;
  wsw_opt_s               opt_reg;
  wsw_flag_s              flag_reg;
  logic [31:0]            base_cnt_reg;
  logic [PRESC_W-1:0]     presc_reg;
  logic [PRESC_W-1:0]     ratio_max;
  logic                   rc_prev_reg;
  logic                   fuse_reg;
  logic                   fuse_loaded_reg;
  logic                   take_block_reg;
  logic [1:0]             sync_out;
  logic                   rc_s;
  logic                   master_clear_pin_n_s;
  logic                   rc_tick;
  logic                   wdt_on;
  logic                   pending;
  logic                   wake_pending;
  logic                   sleep_go;
  logic                   wdt_clr;
  logic                   base_done;
  logic                   timeout;
  logic                   irq_take;
  logic                   apb_setup;
  logic                   apb_write;

  function automatic logic idx_hit(input logic [APB_AW-1:0] a, input logic [7:0] idx);
    idx_hit = (a == APB_AW'({idx, 2'b00}));
  endfunction

  // Pin inputs cross in through the filter
  wsw_sync3 #(
    .W       (2),
    .RST_VAL (2'b10)
  ) wsw_sync3_i (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  ({master_clear_pin_n_i, wdt_rc_clk_i}),
    .sync_o   (sync_out)
  );
  assign master_clear_pin_n_s = sync_out[1];
  assign rc_s     = sync_out[0];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rc_prev_reg <= 1'b0;
    end else begin
      rc_prev_reg <= rc_s;
    end
  end
  assign rc_tick = rc_s & ~rc_prev_reg;

  // Fuse is caught once after reset release; software has no path to it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fuse_reg        <= 1'b0;
      fuse_loaded_reg <= 1'b0;
    end else if (!fuse_loaded_reg) begin
      fuse_reg        <= watchdog_enable_fuse_i;
      fuse_loaded_reg <= 1'b1;
    end
  end
  assign wdt_on = fuse_reg & fuse_loaded_reg;

  assign pending      = |(irq_flag_i & irq_enable_i);
  assign wake_pending = |(irq_flag_i & irq_enable_i & WAKE_CAPABLE);
  assign sleep_go     = (state_reg == WSW_RUN) & sleep_instr_i & ~pending & master_clear_pin_n_s;
  assign wdt_clr      = watchdog_clear_instr_i | sleep_go;

  // Base period counter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      base_cnt_reg <= '0;
    end else if (wdt_clr || !wdt_on || dev_reset_o) begin
      base_cnt_reg <= '0;
    end else if (rc_tick) begin
      base_cnt_reg <= (base_cnt_reg == BASE_MAX) ? '0 : base_cnt_reg + 32'h0000_0001;
    end
  end
  assign base_done = wdt_on & rc_tick & (base_cnt_reg == BASE_MAX) & ~wdt_clr & ~dev_reset_o;

  // Ratio is a power of two; count of base periods minus one
  assign ratio_max = PRESC_W'((8'h01 << opt_reg.prescale_ratio_select) - 8'h01);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      presc_reg <= '0;
    end else if (dev_reset_o) begin
      presc_reg <= '0;
    end else if (opt_reg.prescaler_assign) begin
      if (wdt_clr) begin
        presc_reg <= '0;
      end else if (base_done) begin
        presc_reg <= (presc_reg == ratio_max) ? '0 : presc_reg + 7'h01;
      end
    end
  end
  assign timeout = base_done & (~opt_reg.prescaler_assign | (presc_reg == ratio_max));

  // Sleep state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= WSW_RUN;
    end else begin
      case (state_reg)
        WSW_RUN: begin
          if (sleep_go) begin
            state_reg <= WSW_SLEEP;
          end
        end
        WSW_SLEEP: begin
          if (!master_clear_pin_n_s || timeout || wake_pending) begin
            state_reg <= WSW_RUN;
          end
        end
        default: state_reg <= WSW_RUN;
      endcase
    end
  end

  // Resets: master clear held low, or one cycle for an awake time-out
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dev_reset_o <= 1'b0;
      wdt_reset_o <= 1'b0;
    end else begin
      dev_reset_o <= ~master_clear_pin_n_s | (timeout & (state_reg == WSW_RUN));
      wdt_reset_o <= timeout & (state_reg == WSW_RUN) & master_clear_pin_n_s;
    end
  end

  // Oscillator gate, pin hold, wake strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_drive_en_o <= 1'b1;
      io_hold_o      <= 1'b0;
      wake_o         <= 1'b0;
      wake_vector_o  <= 1'b0;
    end else begin
      wake_o        <= 1'b0;
      wake_vector_o <= 1'b0;
      if (sleep_go) begin
        osc_drive_en_o <= 1'b0;
        io_hold_o      <= 1'b1;
      end else if (state_reg == WSW_SLEEP) begin
        if (!master_clear_pin_n_s) begin
          osc_drive_en_o <= 1'b1;
          io_hold_o      <= 1'b0;
        end else if (timeout || wake_pending) begin
          osc_drive_en_o <= 1'b1;
          io_hold_o      <= 1'b0;
          wake_o         <= 1'b1;
          wake_vector_o  <= wake_pending & global_irq_enable_i;
        end
      end
    end
  end

  // Prefetch address taken with the sleep instruction
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resume_pc_o <= '0;
    end else if (sleep_go) begin
      resume_pc_o <= pc_i + PC_STEP;
    end
  end

  // Status flags; a sleep in the same cycle masks the time-out, so the sleep wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_reg <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};
    end else if (timeout) begin
      flag_reg.timeout_flag_n <= 1'b0;
    end else if (sleep_go) begin
      flag_reg <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b0};
    end else if (watchdog_clear_instr_i) begin
      flag_reg <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};
    end
  end
  assign timeout_flag_n_o   = flag_reg.timeout_flag_n;
  assign powerdown_flag_n_o = flag_reg.powerdown_flag_n;

  // Interrupt take: only the return PC goes to the stack
  assign irq_take = (state_reg == WSW_RUN) & global_irq_enable_i & pending & ~take_block_reg & ~sleep_instr_i;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      take_block_reg <= 1'b0;
      stack_push_o   <= 1'b0;
      stack_data_o   <= '0;
      vector_load_o  <= 1'b0;
      vector_addr_o  <= IRQ_VECTOR;
    end else begin
      stack_push_o  <= irq_take;
      vector_load_o <= irq_take;
      vector_addr_o <= IRQ_VECTOR;
      if (irq_take) begin
        stack_data_o   <= pc_i;
        take_block_reg <= 1'b1;
      end else if (!global_irq_enable_i) begin
        take_block_reg <= 1'b0;
      end
    end
  end

  // APB slave, one access cycle, no wait states
  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      opt_reg <= wsw_opt_s'(OPT_RESET);
    end else if (dev_reset_o) begin
      opt_reg <= wsw_opt_s'(OPT_RESET);
    end else if (apb_write && idx_hit(paddr_i, IDX_OPTION)) begin
      opt_reg <= wsw_opt_s'(pwdata_i[7:0]);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup & ~idx_hit(paddr_i, IDX_OPTION) & ~idx_hit(paddr_i, IDX_STATUS);
      prdata_o  <= '0;
      if (apb_setup && !pwrite_i && idx_hit(paddr_i, IDX_OPTION)) begin
        prdata_o <= {24'h00_0000, opt_reg};
      end else if (apb_setup && !pwrite_i && idx_hit(paddr_i, IDX_STATUS)) begin
        prdata_o[STAT_TO_BIT] <= flag_reg.timeout_flag_n;
        prdata_o[STAT_PD_BIT] <= flag_reg.powerdown_flag_n;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sleep_nop_a: assert property ((state_reg == WSW_RUN) && sleep_instr_i && pending
    |=> (state_reg == WSW_RUN) && $stable(flag_reg.powerdown_flag_n))
    else $error("sleep with pending irq did not act as no-op");
  sleep_entry_a: assert property (sleep_go && !timeout
    |=> !powerdown_flag_n_o && timeout_flag_n_o && !osc_drive_en_o && base_cnt_reg == '0)
    else $error("sleep entry effects missing");
  sleep_noreset_a: assert property ((state_reg == WSW_SLEEP) && timeout && master_clear_pin_n_s
    |=> !wdt_reset_o && wake_o && !dev_reset_o)
    else $error("watchdog reset while asleep");
  timeout_flag_a: assert property (timeout |=> !timeout_flag_n_o)
    else $error("time-out flag not cleared");
  wdt_reset_a: assert property (timeout && (state_reg == WSW_RUN) && master_clear_pin_n_s
    |=> wdt_reset_o && dev_reset_o ##1 !wdt_reset_o)
    else $error("awake time-out did not reset once");
  fuse_off_a: assert property (fuse_loaded_reg && !fuse_reg |-> !timeout)
    else $error("time-out with fuse cleared");
  clear_cnt_a: assert property (wdt_clr && opt_reg.prescaler_assign && !dev_reset_o && !apb_write
    |=> base_cnt_reg == '0 && presc_reg == '0 && $stable(opt_reg))
    else $error("clear did not reset counts");
  io_hold_a: assert property (io_hold_o == (state_reg == WSW_SLEEP) && osc_drive_en_o == !io_hold_o)
    else $error("pins not held in sleep");
  irq_wake_a: assert property ((state_reg == WSW_SLEEP) && wake_pending && master_clear_pin_n_s
    |=> wake_o && wake_vector_o == $past(global_irq_enable_i))
    else $error("interrupt wake wrong");
  master_clear_pin_sleep_a: assert property ((state_reg == WSW_SLEEP) && !master_clear_pin_n_s
    |=> dev_reset_o && !wake_o && state_reg == WSW_RUN)
    else $error("master clear in sleep did not reset");
  push_pc_a: assert property (irq_take
    |=> stack_push_o && stack_data_o == $past(pc_i) && vector_addr_o == IRQ_VECTOR)
    else $error("stack push wrong");
  prefetch_a: assert property (sleep_go |=> resume_pc_o == PC_W'($past(pc_i) + PC_STEP))
    else $error("prefetch address wrong");

  wdt_wake_c: cover property ((state_reg == WSW_SLEEP) && timeout);
  irq_wake_c: cover property ((state_reg == WSW_SLEEP) && wake_pending && global_irq_enable_i);
  master_clear_pin_sleep_c: cover property ((state_reg == WSW_SLEEP) && !master_clear_pin_n_s);
  wdt_reset_c: cover property (wdt_reset_o);
endmodule // wsw_top

// ===== test/wsw_core_model.sv
// Purpose: Core model that issues clear and sleep strobes
// Assumes: Strobes last one clk_i cycle and change just after a rising edge
// Notes:   Global enable is a plain level held until changed
`timescale 1ns/10ps
module wsw_core_model (
  input  wire logic                     clk_i,
  output logic                          clr_o,
  output logic                          sleep_o,
  output logic                          gie_o,
  output logic      [wsw_pkg::PC_W-1:0] pc_o
);
  import wsw_pkg::*;

  initial begin
    clr_o = 1'b0;
    sleep_o = 1'b0;
    gie_o = 1'b0;
    pc_o = '0;
  end

  // PC stays on the bus after the strobe, as a real fetch would leave it
  task automatic strobe(input logic slp, input logic [PC_W-1:0] pc);
    @(posedge clk_i);
    pc_o <= pc;
    clr_o <= ~slp;
    sleep_o <= slp;
    @(posedge clk_i);
    clr_o <= 1'b0;
    sleep_o <= 1'b0;
  endtask

  task automatic set_gie(input logic v);
    @(posedge clk_i);
    gie_o <= v;
  endtask
endmodule // wsw_core_model

// ===== test/watchdog_sleep_wake_control_bench.sv
// Purpose: Self-checking bench for the watchdog and sleep block
// Assumes: Small base period; RC ticks from a free bench oscillator
// Notes:   Tick windows allow one tick of slack for the input filter
`timescale 1ns/10ps
module watchdog_sleep_wake_control_bench;
  import wsw_pkg::*;
  localparam int          BT    = 4;
  localparam logic [11:0] A_OPT = 12'(IDX_OPTION) << BYTE_SHIFT;
  localparam logic [11:0] A_ST  = 12'(IDX_STATUS) << BYTE_SHIFT;
  localparam logic [11:0] A_BAD = 12'h100;
  logic clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, dev_reset_o, wdt_reset_o, osc_drive_en_o, io_hold_o, wake_o, wake_vector_o;
  logic stack_push_o, vector_load_o, timeout_flag_n_o, powerdown_flag_n_o;
  logic wdt_rc_clk_i = 1'b0, master_clear_pin_n_i = 1'b1, watchdog_enable_fuse_i = 1'b1;
  logic watchdog_clear_instr_i, sleep_instr_i, global_irq_enable_i;
  logic [PC_W-1:0] pc_i, resume_pc_o, stack_data_o, vector_addr_o;
  logic [NUM_IRQ-1:0] irq_flag_i = '0, irq_enable_i = '0;
  logic rc_q = 1'b0, dev_at_wdt = 1'b0, vec_seen = 1'b0, got;
  int ticks = 0, n_wdt = 0, n_wake = 0, n_fail = 0, total_checks = 0, t0, n0, k;
  logic [7:0] cfg [4] = '{8'h00, 8'h08, 8'h09, 8'h0A};

  wsw_top #(.BASE_TICKS(BT)) wsw_top_i (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .wdt_rc_clk_i, .master_clear_pin_n_i,
    .watchdog_enable_fuse_i, .watchdog_clear_instr_i, .sleep_instr_i, .global_irq_enable_i, .pc_i,
    .irq_flag_i, .irq_enable_i, .dev_reset_o, .wdt_reset_o, .osc_drive_en_o, .io_hold_o, .wake_o,
    .wake_vector_o, .resume_pc_o, .stack_push_o, .stack_data_o, .vector_load_o, .vector_addr_o,
    .timeout_flag_n_o, .powerdown_flag_n_o);
  wsw_core_model wsw_core_model_i (.clk_i, .clr_o(watchdog_clear_instr_i), .sleep_o(sleep_instr_i),
    .gie_o(global_irq_enable_i), .pc_o(pc_i));

  always #20 clk_i = ~clk_i;
  // Odd half period keeps 19 of every 20 RC edges off the clk_i grid
  always #173 wdt_rc_clk_i = ~wdt_rc_clk_i;

  always @(posedge clk_i) begin
    rc_q <= wdt_rc_clk_i;
    if (wdt_rc_clk_i && !rc_q) ticks <= ticks + 1;
    if (wdt_reset_o) n_wdt <= n_wdt + 1;
    if (wdt_reset_o) dev_at_wdt <= dev_reset_o;
    if (wake_o) n_wake <= n_wake + 1;
    if (wake_o) vec_seen <= wake_vector_o;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bail();
    n_fail++;
    summarize();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) bail();
    rd = prdata_o;
    check(32'(pslverr_o), 32'(a != A_OPT && a != A_ST));
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // Bound doubles as the observation window when no event is wanted
  task automatic wait_ev(input int max, input logic must);
    int base;
    int n;
    base = n_wdt + n_wake;
    n = 0;
    while (n_wdt + n_wake == base && n < max) begin
      @(posedge clk_i);
      n++;
    end
    got = (n_wdt + n_wake != base);
    if (must && !got) bail();
  endtask

  task automatic wait_ticks(input int n);
    int t;
    int c;
    t = ticks;
    c = 0;
    while (ticks < t + n && c < n * 20) begin
      @(posedge clk_i);
      c++;
    end
    if (ticks < t + n) bail();
  endtask

  task automatic irq(input logic [NUM_IRQ-1:0] f, input logic [NUM_IRQ-1:0] e);
    @(posedge clk_i);
    irq_flag_i <= f;
    irq_enable_i <= e;
  endtask

  task automatic sleep_chk(input logic [PC_W-1:0] pc);
    wsw_core_model_i.strobe(1'b1, pc);
    t0 = ticks;
    #1;
    check(32'({io_hold_o, osc_drive_en_o, timeout_flag_n_o, powerdown_flag_n_o, resume_pc_o}),
      32'({4'b1010, pc + PC_STEP}));
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdc(A_OPT, 32'h0000_00FF);
    rdc(A_ST, 32'h0000_0018);
    rdc(A_BAD, 32'h0000_0000);
    apb(1'b1, A_ST, 32'h0000_0000);
    rdc(A_ST, 32'h0000_0018);
    apb(1'b1, A_BAD, 32'h0000_0055);
    apb(1'b1, A_OPT, 32'h0000_005A);
    rdc(A_OPT, 32'h0000_005A);
    foreach (cfg[i]) begin
      // Clear first so a short period cannot expire between the write and the timed clear
      wsw_core_model_i.strobe(1'b0, 13'h0010);
      apb(1'b1, A_OPT, 32'(cfg[i]));
      wsw_core_model_i.strobe(1'b0, 13'h0010);
      t0 = ticks;
      n0 = n_wdt;
      rdc(A_OPT, 32'(cfg[i]));
      wait_ev(400, 1'b1);
      k = cfg[i][3] ? BT << cfg[i][2:0] : BT;
      check(32'(ticks - t0 >= k - 1 && ticks - t0 <= k + 1), 32'h1);
      check(32'(n_wdt - n0), 32'h1);
      check(32'(dev_at_wdt), 32'h1);
      rdc(A_ST, 32'h0000_0008);
    end
    apb(1'b1, A_OPT, 32'h0000_0008);
    n0 = n_wdt;
    repeat (5) begin
      wsw_core_model_i.strobe(1'b0, 13'h0011);
      wait_ticks(BT - 2);
    end
    check(32'(n_wdt - n0), 32'h0);
    apb(1'b1, A_OPT, 32'h0000_0009);
    sleep_chk(13'h0123);
    wait_ev(400, 1'b1);
    check(32'(ticks - t0 >= 2 * BT - 1 && ticks - t0 <= 2 * BT + 1), 32'h1);
    check(32'(n_wdt - n0), 32'h0);
    check(32'({vec_seen, io_hold_o, osc_drive_en_o}), 32'h1);
    rdc(A_ST, 32'h0000_0000);
    apb(1'b1, A_OPT, 32'h0000_000F);
    for (int i = 0; i < NUM_IRQ; i++) begin
      wsw_core_model_i.set_gie(i[0]);
      sleep_chk(13'h0200);
      irq(11'(1 << i), 11'h000);
      wait_ev(12, 1'b0);
      check(32'(got), 32'h0);
      irq(11'(1 << i), 11'(1 << i));
      wait_ev(12, 1'b0);
      check(32'(got), 32'(WAKE_CAPABLE[i]));
      if (!got) begin
        irq(11'h001, 11'h001);
        wait_ev(12, 1'b1);
      end
      check(32'(vec_seen), 32'(i[0]));
      irq(11'h000, 11'h000);
      wsw_core_model_i.set_gie(1'b0);
    end
    wsw_core_model_i.strobe(1'b0, 13'h0456);
    irq(11'h001, 11'h001);
    wsw_core_model_i.strobe(1'b1, 13'h0457);
    #1;
    check(32'({io_hold_o, powerdown_flag_n_o, timeout_flag_n_o}), 32'h3);
    wsw_core_model_i.set_gie(1'b1);
    k = 0;
    while (stack_push_o !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 20) bail();
    check(32'({vector_load_o, vector_addr_o, stack_data_o}), 32'({1'b1, IRQ_VECTOR, 13'h0457}));
    irq(11'h000, 11'h000);
    wsw_core_model_i.set_gie(1'b0);
    sleep_chk(13'h0300);
    n0 = n_wake;
    @(posedge clk_i);
    master_clear_pin_n_i <= 1'b0;
    k = 0;
    while (dev_reset_o !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 20) bail();
    repeat (4) @(posedge clk_i);
    master_clear_pin_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    check(32'(n_wake - n0), 32'h0);
    check(32'({io_hold_o, osc_drive_en_o, dev_reset_o}), 32'h2);
    rdc(A_ST, 32'h0000_0010);
    rdc(A_OPT, 32'h0000_00FF);
    // Second power-on reset with the fuse cleared; later fuse changes must not matter
    watchdog_enable_fuse_i <= 1'b0;
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    watchdog_enable_fuse_i <= 1'b1;
    rdc(A_ST, 32'h0000_0018);
    apb(1'b1, A_OPT, 32'h0000_0000);
    sleep_chk(13'h0400);
    wait_ev(BT * 30, 1'b0);
    check(32'(got), 32'h0);
    irq(11'h001, 11'h001);
    wait_ev(12, 1'b1);
    irq(11'h000, 11'h000);
    summarize();
  end
endmodule // watchdog_sleep_wake_control_bench
